/* verilog/nsapt_pkg.sv */
package nsapt_pkg;
    localparam int CLK_HZ        = 20_000_000;
    localparam int TC_HZ         = 1_020_000;
    localparam int TC_STEP       = TC_HZ / 1000;
    localparam int TC_MOD        = CLK_HZ / 1000;
    localparam int SEQ_PERIOD_S  = 10;
    localparam int ENV_PERIOD_MS = 100;
    // Carrier base rate 1133-1/3 per second, held times three
    localparam int CAR_RATE_X3   = 3400;
    localparam int CODE_CYCLE    = TC_HZ * SEQ_PERIOD_S;
    localparam int ENV_CODES     = TC_HZ / 1000 * ENV_PERIOD_MS;
    localparam int INT_CODES     = TC_HZ * 3 / CAR_RATE_X3;
    localparam int NLAG          = CODE_CYCLE / ENV_CODES;
    localparam int NCAR          = 3;
    localparam int NSTA          = 8;
    localparam int NQUAD         = 4;
    localparam int PH_FRAC       = 10;
    localparam int VEL_SHIFT     = 4;
    localparam int RO_WORDS      = 4;

    localparam logic [2:0] OP_TRANSMIT  = 3'h0;
    localparam logic [2:0] OP_CLR_ADD   = 3'h1;
    localparam logic [2:0] OP_ADD       = 3'h2;
    localparam logic [2:0] OP_SUB       = 3'h3;
    localparam logic [2:0] OP_ADD_RIGHT = 3'h4;
    localparam logic [2:0] OP_ADD_LEFT  = 3'h6;

    localparam logic [1:0] SEL_ENV  = 2'h3;
    localparam logic [7:0] ADC_TMO  = 8'hFF;
    localparam logic [6:0] SLOT_NONE = 7'h7F;

    // Sector start slot and length in tenths of a second; the rest are gaps
    localparam logic [6:0] SECT_START [NSTA] = '{7'h00, 7'h0C, 7'h18, 7'h25, 7'h32, 7'h3E, 7'h4B, 7'h57};
    localparam logic [6:0] SECT_LEN   [NSTA] = '{7'h0A, 7'h0A, 7'h0B, 7'h0B, 7'h0A, 7'h0B, 7'h0A, 7'h0B};

    typedef enum {ST_IDLE, ST_CAR, ST_ENV, ST_WALK, ST_READ} nsapt_state_t;
endpackage : nsapt_pkg

/* verilog/nsapt_top.sv */
// What this block does
// R1: Processing repeats every ten seconds, matching the received sequence period.
// R2: One hundred correlation accumulators, one per possible sequence displacement.
// R3: Every 102,000 time codes an envelope sample enters the arithmetic register.
// R4: That sample is added or subtracted at all 100 accumulators by lag.
// R5: Largest correlation reloads the program slot counter, aligning to the sequence.
// R6: Correlation accumulates forever, independent of tracking, as a long average.
// R7: At each interval start the first component's phase word loads the time code register.
// R8: Carrier sample adds into velocity word; velocity integrates into phase word.
// R9: After each sample the next component's phase word times the next sample.
// R10: Sampling interval 900 codes, 1133-1/3 per second; three carriers per interval.
// R11: Carrier samples rotate over four accumulators for modulation phase recovery.
// R12: Per component velocity, phase and quadrant totals form a second-order loop.
// R13: In gaps and idle sectors, phase differences are combined and sent out.
// R14: Fully cyclic with no start command; converges from any state.
// R15: Sequence and interval timing comes from a 1.02 MHz time code enable; the ADC timeout and lag walk count system clocks.
// R16: Three-bit operation codes select transmit, add, subtract and shifted adds.
// R17: Correlation lag index advances modulo one hundred per envelope sample.
`timescale 1ns/100ps
module nsapt_top
    import nsapt_pkg::*;
#(
    parameter int              ENV_CODES_P = ENV_CODES,
    parameter int              AW          = 12,
    parameter int              CW          = 24,
    parameter logic [NSTA-1:0] STA_MASK    = 8'h0F,
    parameter int              PAIR_A      = 0,
    parameter int              PAIR_B      = 1,
    parameter int              LANE_K      = 9
) (
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST_N,
    input  wire logic signed [AW-1:0] ADC_DATA,
    input  wire logic                 ADC_VALID,
    output logic                      SAMPLE_REQ,
    output logic             [1:0]    SAMPLE_SEL,
    output logic                      RD_VALID,
    input  wire logic                 RD_READY,
    output logic             [15:0]   RD_DATA,
    output logic             [1:0]    RD_TAG,
    output logic             [6:0]    SEQ_SLOT
);
    localparam int              PHW     = 20;
    localparam logic [9:0]      INT_C10 = 10'(INT_CODES);
    localparam logic [PHW-1:0]  PH_WRAP = PHW'(INT_CODES << PH_FRAC);

    function automatic logic [3:0] sector_info(input logic [6:0] slot);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < NSTA; i++) begin
            if (slot >= SECT_START[i] && {1'b0, slot} < {1'b0, SECT_START[i]} + {1'b0, SECT_LEN[i]}) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction : sector_info

    function automatic logic [6:0] lag_sub(input logic [6:0] a, input logic [6:0] b);
        logic [7:0] t;
        t = {1'b0, a} + 8'(NLAG) - {1'b0, b};
        return (t >= 8'(NLAG)) ? 7'(t - 8'(NLAG)) : 7'(t);
    endfunction : lag_sub

    function automatic logic signed [CW-1:0] arith(input logic [2:0] op, input logic signed [CW-1:0] a,
                                                   input logic signed [CW-1:0] b);
        case (op) // see R16
            OP_CLR_ADD:   return b;
            OP_ADD:       return a + b;
            OP_SUB:       return a - b;
            OP_ADD_RIGHT: return a + (b >>> 1);
            OP_ADD_LEFT:  return a + (b <<< 1);
            default:      return a;
        endcase
    endfunction : arith

    function automatic logic [9:0] ph_dif(input logic [9:0] a, input logic [9:0] b);
        return (a >= b) ? 10'(a - b) : 10'(a + INT_C10 - b);
    endfunction : ph_dif

    // Reset release
    logic rst_s1_ff;
    logic rst_n_ff;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    // Time code: env_cnt and lag together span the ten-second cycle
    logic [14:0] tc_acc_ff, nxt_tc_acc;
    logic [16:0] env_cnt_ff, nxt_env_cnt;
    logic [9:0]  int_cnt_ff, nxt_int_cnt;
    logic [6:0]  lag_ff, nxt_lag;
    logic        tc_en;
    logic        env_tick;
    logic        int_tick;

    always_comb begin
        tc_en       = tc_acc_ff >= 15'(TC_MOD - TC_STEP); // see R15
        nxt_tc_acc  = tc_en ? 15'(tc_acc_ff + 15'(TC_STEP) - 15'(TC_MOD)) : 15'(tc_acc_ff + 15'(TC_STEP));
        env_tick    = tc_en && (env_cnt_ff == 17'(ENV_CODES_P - 1)); // see R3
        int_tick    = tc_en && (int_cnt_ff == 10'(INT_CODES - 1)); // see R10
        nxt_env_cnt = env_cnt_ff;
        nxt_int_cnt = int_cnt_ff;
        nxt_lag     = lag_ff;
        if (tc_en) begin
            nxt_env_cnt = env_tick ? 17'h00000 : 17'(env_cnt_ff + 17'h00001);
            nxt_int_cnt = int_tick ? 10'h000 : 10'(int_cnt_ff + 10'h001);
        end
        if (env_tick) begin
            nxt_lag = (lag_ff == 7'(NLAG - 1)) ? 7'h00 : 7'(lag_ff + 7'h01); // see R17, R1
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            tc_acc_ff  <= 15'h0000;
            env_cnt_ff <= 17'h00000;
            int_cnt_ff <= 10'h000;
            lag_ff     <= 7'h00;
        end else begin
            tc_acc_ff  <= nxt_tc_acc;
            env_cnt_ff <= nxt_env_cnt;
            int_cnt_ff <= nxt_int_cnt;
            lag_ff     <= nxt_lag;
        end
    end

    // Processing state
    nsapt_state_t            st_ff, nxt_st;
    logic signed [CW-1:0]    corr_ff [NLAG]; // see R2
    logic signed [CW-1:0]    nxt_corr [NLAG];
    logic signed [CW-1:0]    vel_ff [NSTA][NCAR];
    logic signed [CW-1:0]    nxt_vel [NSTA][NCAR];
    logic signed [CW-1:0]    quad_ff [NSTA][NCAR][NQUAD];
    logic signed [CW-1:0]    nxt_quad [NSTA][NCAR][NQUAD];
    logic        [PHW-1:0]   phase_ff [NSTA][NCAR];
    logic        [PHW-1:0]   nxt_phase [NSTA][NCAR];
    logic signed [CW-1:0]    acc_ff, nxt_acc;
    logic signed [CW-1:0]    best_val_ff, nxt_best_val;
    logic        [6:0]       walk_ff, nxt_walk;
    logic        [6:0]       best_ff, nxt_best;
    logic        [6:0]       pc_slot_ff, nxt_pc_slot;
    logic        [6:0]       ro_done_ff, nxt_ro_done;
    logic        [1:0]       ro_idx_ff, nxt_ro_idx;
    logic        [1:0]       car_ff, nxt_car;
    logic        [1:0]       qix_ff, nxt_qix;
    logic        [2:0]       sta_ff, nxt_sta;
    logic        [9:0]       tc_reg_ff, nxt_tc_reg;
    logic        [7:0]       tmo_ff, nxt_tmo;
    logic                    busy_ff, nxt_busy;
    logic                    env_pend_ff, nxt_env_pend;
    logic                    req_ff, nxt_req;
    logic        [1:0]       sel_ff, nxt_sel;
    logic        [3:0]       si;
    logic        [3:0]       wsi;
    logic                    trk_now;
    logic                    fire;
    logic signed [CW-1:0]    samp;
    logic signed [CW-1:0]    nv;
    logic signed [PHW+1:0]   pn;
    logic        [6:0]       win;
    logic        [9:0]       dif [NCAR];
    logic        [9:0]       coarse;
    logic        [19:0]      lane_t;
    logic        [15:0]      resolved;
    logic                    fifo_in_valid;
    logic                    fifo_in_ready;
    logic        [17:0]      fifo_in_data;

    always_comb begin
        nxt_st       = st_ff;
        nxt_corr     = corr_ff;
        nxt_vel      = vel_ff;
        nxt_quad     = quad_ff;
        nxt_phase    = phase_ff;
        nxt_acc      = acc_ff;
        nxt_best_val = best_val_ff;
        nxt_walk     = walk_ff;
        nxt_best     = best_ff;
        nxt_pc_slot  = pc_slot_ff;
        nxt_ro_done  = ro_done_ff;
        nxt_ro_idx   = ro_idx_ff;
        nxt_car      = car_ff;
        nxt_qix      = qix_ff;
        nxt_sta      = sta_ff;
        nxt_tc_reg   = tc_reg_ff;
        nxt_tmo      = tmo_ff;
        nxt_busy     = busy_ff;
        nxt_env_pend = env_pend_ff || env_tick;
        nxt_req      = 1'b0;
        nxt_sel      = sel_ff;
        samp         = CW'(ADC_DATA);
        nv           = '0;
        pn           = '0;
        win          = best_ff;
        si           = sector_info(pc_slot_ff);
        wsi          = sector_info(lag_sub(lag_ff, walk_ff));
        trk_now      = si[3] && STA_MASK[si[2:0]];
        fire         = busy_ff && (int_cnt_ff >= tc_reg_ff); // see R9
        for (int c = 0; c < NCAR; c++) begin
            dif[c] = ph_dif(phase_ff[PAIR_A][c][PHW-1:PH_FRAC], phase_ff[PAIR_B][c][PHW-1:PH_FRAC]);
        end
        // Difference-frequency lane picks the whole count, fine phase the fraction
        coarse        = ph_dif(dif[0], dif[1]); // see R13
        lane_t        = 20'(LANE_K) * {10'h000, coarse} + 20'(INT_CODES / 2) + 20'(INT_CODES) - {10'h000, dif[0]};
        resolved      = 16'((lane_t / 20'(INT_CODES)) * 20'(INT_CODES) + {10'h000, dif[0]});
        fifo_in_valid = 1'b0;
        fifo_in_data  = (ro_idx_ff == 2'(RO_WORDS - 1)) ? {ro_idx_ff, resolved} : {ro_idx_ff, 6'h00, dif[ro_idx_ff]};
        if (env_tick) begin
            nxt_pc_slot = (pc_slot_ff == 7'(NLAG - 1)) ? 7'h00 : 7'(pc_slot_ff + 7'h01);
        end
        case (st_ff)
            ST_IDLE: begin
                nxt_tmo = 8'h00;
                if (fire) begin
                    nxt_req = 1'b1;
                    nxt_sel = car_ff;
                    nxt_st  = ST_CAR;
                end else if (env_pend_ff) begin
                    nxt_req      = 1'b1;
                    nxt_sel      = SEL_ENV;
                    nxt_st       = ST_ENV;
                    nxt_env_pend = env_tick;
                end else if (!trk_now && ro_done_ff != pc_slot_ff) begin // see R13
                    nxt_ro_idx = 2'h0;
                    nxt_st     = ST_READ;
                end
            end
            ST_CAR: begin
                nxt_tmo = 8'(tmo_ff + 8'h01);
                if (ADC_VALID) begin
                    nv = arith(OP_ADD, vel_ff[sta_ff][car_ff], samp); // see R8, R12
                    nxt_vel[sta_ff][car_ff] = nv;
                    pn = $signed({2'b00, phase_ff[sta_ff][car_ff]}) + (PHW+2)'(nv >>> VEL_SHIFT);
                    if (pn < 0) begin
                        pn = pn + $signed({2'b00, PH_WRAP});
                    end else if (pn >= $signed({2'b00, PH_WRAP})) begin
                        pn = pn - $signed({2'b00, PH_WRAP});
                    end
                    nxt_phase[sta_ff][car_ff] = PHW'(pn);
                    nxt_quad[sta_ff][car_ff][qix_ff] = arith(OP_ADD, quad_ff[sta_ff][car_ff][qix_ff], samp); // see R11
                    if (car_ff == 2'(NCAR - 1)) begin
                        nxt_busy = 1'b0;
                    end else begin
                        nxt_car    = 2'(car_ff + 2'h1);
                        nxt_tc_reg = phase_ff[sta_ff][2'(car_ff + 2'h1)][PHW-1:PH_FRAC]; // see R9
                    end
                    nxt_st = ST_IDLE;
                end else if (tmo_ff == ADC_TMO) begin
                    nxt_busy = 1'b0;
                    nxt_st   = ST_IDLE;
                end
            end
            ST_ENV: begin
                nxt_tmo = 8'(tmo_ff + 8'h01);
                if (ADC_VALID) begin
                    nxt_acc      = arith(OP_CLR_ADD, acc_ff, samp); // see R3
                    nxt_walk     = 7'h00;
                    nxt_best     = 7'h00;
                    nxt_best_val = {1'b1, {(CW-1){1'b0}}};
                    nxt_st       = ST_WALK;
                end else if (tmo_ff == ADC_TMO) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_WALK: begin
                // One lag per cycle: carrier timing may slip by up to 100 cycles
                nv = arith(wsi[3] ? OP_ADD : OP_SUB, corr_ff[walk_ff], acc_ff); // see R4, R6
                nxt_corr[walk_ff] = nv;
                if (nv > best_val_ff) begin // see R5
                    nxt_best_val = nv;
                    nxt_best     = walk_ff;
                    win          = walk_ff;
                end
                if (walk_ff == 7'(NLAG - 1)) begin
                    nxt_pc_slot = lag_sub(nxt_lag, win); // see R5
                    nxt_st      = ST_IDLE;
                end else begin
                    nxt_walk = 7'(walk_ff + 7'h01);
                end
            end
            ST_READ: begin
                fifo_in_valid = 1'b1;
                if (fifo_in_ready) begin
                    if (ro_idx_ff == 2'(RO_WORDS - 1)) begin
                        nxt_ro_done = pc_slot_ff;
                        nxt_st      = ST_IDLE;
                    end else begin
                        nxt_ro_idx = 2'(ro_idx_ff + 2'h1);
                    end
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
        // A new interval restarts the carrier round, whatever is left over
        if (int_tick) begin
            nxt_car    = 2'h0;
            nxt_busy   = trk_now;
            nxt_sta    = si[2:0];
            nxt_tc_reg = phase_ff[si[2:0]][0][PHW-1:PH_FRAC]; // see R7
            nxt_qix    = 2'(qix_ff + 2'h1); // see R11
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            st_ff       <= ST_IDLE;
            corr_ff     <= '{default: '0};
            vel_ff      <= '{default: '{default: '0}};
            quad_ff     <= '{default: '{default: '{default: '0}}};
            phase_ff    <= '{default: '{default: '0}};
            acc_ff      <= '0;
            best_val_ff <= '0;
            walk_ff     <= 7'h00;
            best_ff     <= 7'h00;
            pc_slot_ff  <= 7'h00;
            ro_done_ff  <= SLOT_NONE;
            ro_idx_ff   <= 2'h0;
            car_ff      <= 2'h0;
            qix_ff      <= 2'h0;
            sta_ff      <= 3'h0;
            tc_reg_ff   <= 10'h000;
            tmo_ff      <= 8'h00;
            busy_ff     <= 1'b0;
            env_pend_ff <= 1'b0;
            req_ff      <= 1'b0;
            sel_ff      <= 2'h0;
        end else begin
            st_ff       <= nxt_st;
            corr_ff     <= nxt_corr;
            vel_ff      <= nxt_vel;
            quad_ff     <= nxt_quad;
            phase_ff    <= nxt_phase;
            acc_ff      <= nxt_acc;
            best_val_ff <= nxt_best_val;
            walk_ff     <= nxt_walk;
            best_ff     <= nxt_best;
            pc_slot_ff  <= nxt_pc_slot;
            ro_done_ff  <= nxt_ro_done;
            ro_idx_ff   <= nxt_ro_idx;
            car_ff      <= nxt_car;
            qix_ff      <= nxt_qix;
            sta_ff      <= nxt_sta;
            tc_reg_ff   <= nxt_tc_reg;
            tmo_ff      <= nxt_tmo;
            busy_ff     <= nxt_busy;
            env_pend_ff <= nxt_env_pend;
            req_ff      <= nxt_req;
            sel_ff      <= nxt_sel;
        end
    end

    // Two-entry readout buffer; a full buffer holds the readout state
    logic [17:0] mem_ff [2];
    logic [17:0] nxt_mem [2];
    logic        wp_ff, nxt_wp;
    logic        rp_ff, nxt_rp;
    logic [1:0]  cnt_ff, nxt_cnt;
    logic        push;
    logic        pop;

    always_comb begin
        fifo_in_ready = cnt_ff != 2'h2;
        push          = fifo_in_valid && fifo_in_ready;
        pop           = (cnt_ff != 2'h0) && RD_READY;
        nxt_mem       = mem_ff;
        nxt_wp        = wp_ff;
        nxt_rp        = rp_ff;
        if (push) begin
            nxt_mem[wp_ff] = fifo_in_data;
            nxt_wp         = !wp_ff;
        end
        if (pop) begin
            nxt_rp = !rp_ff;
        end
        nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mem_ff <= '{default: '0};
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            mem_ff <= nxt_mem;
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end

    assign RD_VALID   = cnt_ff != 2'h0;
    assign RD_TAG     = mem_ff[rp_ff][17:16];
    assign RD_DATA    = mem_ff[rp_ff][15:0];
    assign SAMPLE_REQ = req_ff;
    assign SAMPLE_SEL = sel_ff;
    assign SEQ_SLOT   = pc_slot_ff; // see R14
endmodule : nsapt_top

/* verif/nsapt_checker.sv */
`timescale 1ns/100ps
module nsapt_checker
    import nsapt_pkg::*;
#(
    parameter int ENV_CODES_P = ENV_CODES
) (
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    input wire logic        ADC_VALID,
    input wire logic        SAMPLE_REQ,
    input wire logic [1:0]  SAMPLE_SEL,
    input wire logic        RD_VALID,
    input wire logic        RD_READY,
    input wire logic [15:0] RD_DATA,
    input wire logic [1:0]  RD_TAG,
    input wire logic [6:0]  SEQ_SLOT
);
    // Slack covers carrier priority, slow answers and one abandoned request
    localparam int ENV_HI = ENV_CODES_P * (CLK_HZ / 1000) / (TC_HZ / 1000) + 1000;
    logic        pend_ff;
    logic        nxt_pend;
    logic [8:0]  wait_ff;
    logic [8:0]  nxt_wait;
    logic [31:0] env_ff;
    logic [31:0] nxt_env;
    logic [1:0]  tag_ff;
    logic [1:0]  nxt_tag;
    logic        env_req;
    logic        pop;

    assign env_req = SAMPLE_REQ && (SAMPLE_SEL == SEL_ENV);
    assign pop     = RD_VALID && RD_READY;

    always_comb begin
        nxt_pend = SAMPLE_REQ || (pend_ff && !ADC_VALID);
        nxt_wait = SAMPLE_REQ ? 9'h000 : ((wait_ff == 9'h1FF) ? wait_ff : wait_ff + 9'h001);
        nxt_env  = env_req ? 32'h0 : env_ff + 32'h1;
        nxt_tag  = pop ? RD_TAG : tag_ff;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pend_ff <= 1'b0;
            wait_ff <= 9'h000;
            env_ff  <= 32'h0;
            tag_ff  <= 2'h3;
        end else begin
            pend_ff <= nxt_pend;
            wait_ff <= nxt_wait;
            env_ff  <= nxt_env;
            tag_ff  <= nxt_tag;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    AST_REQ_PULSE: assert property (SAMPLE_REQ |=> !SAMPLE_REQ)
        else $error("request wider than one cycle");
    AST_ONE_OUT: assert property (SAMPLE_REQ |-> !pend_ff || wait_ff >= 9'h100)
        else $error("second request while one outstanding");
    AST_SEL_HOLD: assert property (!SAMPLE_REQ |-> $stable(SAMPLE_SEL))
        else $error("channel select moved without request");
    AST_ENV_MAX: assert property (env_ff <= ENV_HI)
        else $error("envelope request overdue");
    AST_SLOT_RANGE: assert property (SEQ_SLOT < 7'h64)
        else $error("slot outside 0 to 99");
    AST_RD_HOLD: assert property (RD_VALID && !RD_READY |=> RD_VALID && $stable(RD_DATA) && $stable(RD_TAG))
        else $error("readout word moved while stalled");
    AST_TAG_ORDER: assert property (pop |-> RD_TAG == tag_ff + 2'h1)
        else $error("readout tags out of order");
    AST_DIFF_RANGE: assert property (RD_VALID && RD_TAG != 2'h3 |-> RD_DATA < 16'h0384)
        else $error("phase difference beyond one interval");
    AST_RESET_QUIET: assert property (disable iff (1'b0) !RST_N |-> !SAMPLE_REQ && !RD_VALID && SEQ_SLOT == 7'h00)
        else $error("outputs active in reset");

    COV_ENV: cover property (env_req);
    COV_REPORT: cover property (pop && RD_TAG == 2'h3);
    COV_STALL: cover property (RD_VALID && !RD_READY [*8]);
    COV_ABANDON: cover property (pend_ff && wait_ff == 9'h0FF);
endmodule : nsapt_checker

bind nsapt_top nsapt_checker #(.ENV_CODES_P(ENV_CODES_P)) u_nsapt_checker (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADC_VALID(ADC_VALID), .SAMPLE_REQ(SAMPLE_REQ),
    .SAMPLE_SEL(SAMPLE_SEL), .RD_VALID(RD_VALID), .RD_READY(RD_READY), .RD_DATA(RD_DATA),
    .RD_TAG(RD_TAG), .SEQ_SLOT(SEQ_SLOT));

/* verif/nsapt_adc_model.sv */
`timescale 1ns/100ps
module nsapt_adc_model
    import nsapt_pkg::*;
#(
    parameter int         ENV_CODES_P = 20,
    parameter logic [6:0] OFFSET      = 7'h25
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               sample_req,
    input  wire logic        [1:0]  sample_sel,
    input  wire logic               slow,
    input  wire logic               drop,
    output logic                    adc_valid,
    output logic signed      [11:0] adc_data,
    output logic             [6:0]  seq_pos
);
    int         acc;
    int         code;
    int         dly;
    int         nreq;
    logic       busy;
    logic [1:0] sel;

    function automatic logic in_sector(input logic [6:0] s);
        in_sector = 1'b0;
        for (int i = 0; i < NSTA; i++) begin
            if (s >= SECT_START[i] && s < SECT_START[i] + SECT_LEN[i]) begin
                in_sector = 1'b1;
            end
        end
    endfunction : in_sector

    initial begin
        adc_valid = 1'b0;
        adc_data  = 12'h000;
        seq_pos   = OFFSET;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc = 0;
            code = 0;
            nreq = 0;
            busy = 1'b0;
            adc_valid <= 1'b0;
            seq_pos <= OFFSET;
        end else begin
            // Far sequence keeps its own time, unrelated to the receiver's slot
            acc = acc + 1020;
            if (acc >= 20000) begin
                acc = acc - 20000;
                code = code + 1;
            end
            if (code == ENV_CODES_P) begin
                code = 0;
                seq_pos <= (seq_pos == 7'h63) ? 7'h00 : seq_pos + 7'h01;
            end
            if (busy) dly = dly - 1;
            if (busy && dly == 0) begin
                busy = 1'b0;
                adc_valid <= 1'b1;
                if (sel == SEL_ENV) adc_data <= in_sector(seq_pos) ? 12'h190 : 12'hE70;
                else adc_data <= nreq[0] ? 12'h050 : 12'hFB0;
            end else begin
                adc_valid <= 1'b0;
                // Released bus toggles so stale data never looks valid
                adc_data <= ~adc_data;
            end
            if (sample_req && !drop) begin
                busy = 1'b1;
                sel = sample_sel;
                nreq = nreq + 1;
                dly = slow ? 60 : 1 + nreq % 5;
            end
        end
    end
endmodule : nsapt_adc_model

/* verif/tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb_top
    import nsapt_pkg::*;
;
    localparam int ENVP = 20;
    localparam int LANE = 9;
    logic               CLK_SYS, RST_N, ADC_VALID, SAMPLE_REQ, RD_VALID, RD_READY, slow, drop, stall;
    logic signed [11:0] ADC_DATA;
    logic        [1:0]  SAMPLE_SEL, RD_TAG;
    logic        [15:0] RD_DATA, d0, d1;
    logic        [6:0]  SEQ_SLOT, seq_pos;
    int                 fails = 0, num_checks = 0, reports = 0, n_env = 0, cyc = 0, seed, t0;
    int                 n_car [3] = '{0, 0, 0};

    nsapt_top #(.ENV_CODES_P(ENVP), .LANE_K(LANE)) DUT (
        .CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADC_DATA(ADC_DATA), .ADC_VALID(ADC_VALID),
        .SAMPLE_REQ(SAMPLE_REQ), .SAMPLE_SEL(SAMPLE_SEL), .RD_VALID(RD_VALID), .RD_READY(RD_READY),
        .RD_DATA(RD_DATA), .RD_TAG(RD_TAG), .SEQ_SLOT(SEQ_SLOT));
    nsapt_adc_model #(.ENV_CODES_P(ENVP), .OFFSET(7'h25)) u_adc (
        .clk(CLK_SYS), .rst_n(RST_N), .sample_req(SAMPLE_REQ), .sample_sel(SAMPLE_SEL), .slow(slow),
        .drop(drop), .adc_valid(ADC_VALID), .adc_data(ADC_DATA), .seq_pos(seq_pos));

    function automatic logic [15:0] exp_lane(input logic [15:0] a, input logic [15:0] b);
        int c;
        c = (int'(a) - int'(b) + 900) % 900;
        return 16'((LANE * c + 1350 - int'(a)) / 900 * 900 + int'(a));
    endfunction : exp_lane

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic wait_req(input int lim, output int n);
        n = 0;
        while (SAMPLE_REQ !== 1'b1 && n < lim) begin
            @(posedge CLK_SYS);
            #1 n++;
        end
    endtask : wait_req

    initial begin
        CLK_SYS = 1'b0;
        forever #25 CLK_SYS = ~CLK_SYS;
    end

    always @(posedge CLK_SYS) begin
        #1 RD_READY = !stall && ($random(seed) % 4 != 0);
        cyc++;
    end

    always @(posedge CLK_SYS) begin
        if (RST_N && RD_VALID === 1'b1 && RD_READY === 1'b1) begin
            if (RD_TAG == 2'h0) d0 = RD_DATA;
            if (RD_TAG == 2'h1) d1 = RD_DATA;
            if (RD_TAG == 2'h3) begin
                `CHK(RD_DATA, exp_lane(d0, d1))
                reports++;
            end
        end
        if (RST_N && SAMPLE_REQ === 1'b1) begin
            if (SAMPLE_SEL == SEL_ENV) n_env++;
            else n_car[SAMPLE_SEL]++;
        end
    end

    initial begin
        #(95000 * 50);
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end

    initial begin
        seed = 35514;
        RST_N = 1'b1;
        {slow, drop, stall} = 3'h0;
        #1 RST_N = 1'b0;
        repeat (10) @(posedge CLK_SYS);
        #1 `CHK(SAMPLE_REQ, 1'b0)
        `CHK(RD_VALID, 1'b0)
        `CHK(SEQ_SLOT, 7'h00)
        RST_N = 1'b1;
        cyc = 0;
        wait_req(2000, t0);
        `CHK(t0 < 2000, 1'b1)
        $display("test start done");
        stall = 1'b1;
        t0 = 0;
        while (RD_VALID !== 1'b1 && t0 < 6000) begin
            @(posedge CLK_SYS);
            #1 t0++;
        end
        repeat (200) @(posedge CLK_SYS);
        #1 `CHK(RD_VALID, 1'b1)
        stall = 1'b0;
        $display("test stall done");
        drop = 1'b1;
        wait_req(3000, t0);
        #50 drop = 1'b0;
        wait_req(3000, t0);
        `CHK(t0 >= 256 && t0 < 3000, 1'b1)
        $display("test abandon done");
        slow = 1'b1;
        repeat (20000) @(posedge CLK_SYS);
        #1 slow = 1'b0;
        $display("test slow done");
        while (cyc < 85000) @(posedge CLK_SYS);
        `CHK(n_env >= cyc * 1020 / 20000 / ENVP - 3, 1'b1)
        `CHK(n_env <= cyc * 1020 / 20000 / ENVP + 1, 1'b1)
        for (int i = 0; i < NCAR; i++) `CHK(n_car[i] >= cyc * 1020 / 20000 / 900 - 2, 1'b1)
        `CHK(reports > 0, 1'b1)
        for (int k = 0; k < 3; k++) begin
            @(seq_pos);
            repeat (190) @(posedge CLK_SYS);
            #1 `CHK((int'(SEQ_SLOT) - int'(seq_pos) + 101) % 100 <= 2, 1'b1)
        end
        $display("test align done");
        conclude();
    end
endmodule : tb_top
